// ==== sdp_pkg.sv ====
// Constants and types shared by the serial converter input port
// How it works
// - Host drops frame-sync low; shifting is enabled only while it stays low
// - Each of the first sixteen falling shift-clock edges shifts the data bit into a 16-bit register
// - After the sixteenth falling edge the word goes on to update the converter
// - Frame-sync rising before sixteen edges aborts; partial word dropped, code kept
// - Reset forces code zero; it stays zero until the first complete frame
// - Power-down mode comes from a field inside the serial word, no extra pin
// - The held converter code is 12 bits, one code per 16-bit frame
package sdp_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int          WORD_BITS      = 16;
  localparam int          CODE_BITS      = 12;
  localparam int          PD_BITS        = 2;
  localparam int          FIFO_DEPTH     = 16;
  localparam logic [4:0]  CNT_ZERO       = 5'h00;
  localparam logic [4:0]  CNT_ONE        = 5'h01;
  localparam logic [4:0]  LAST_BIT       = 5'h0F;
  localparam logic [4:0]  BITS_PER_FRAME = 5'h10;

  // ****************************************
  // Reset values and clock figures
  // ****************************************
  localparam logic [11:0] CODE_RESET     = 12'h000;
  localparam logic [1:0]  PD_NORMAL      = 2'h0;
  localparam logic [15:0] WORD_RESET     = 16'h0000;
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          SCLK_MAX_HZ    = 30_000_000;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [1:0]  spare;
    logic [1:0]  pd_mode;
    logic [11:0] code;
  } sdp_word_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_SHIFT = 2'h1,
    ST_HOLD  = 2'h3
  } sdp_state_e;

  typedef struct packed {
    logic [2:0]  sync_ff;
    logic [2:0]  sclk_ff;
    logic [2:0]  din_ff;
    logic        sync_n_f;
    logic        sclk_f;
    logic        din_f;
    sdp_state_e  st;
    logic [15:0] shreg;
    logic [4:0]  cnt;
    logic        push;
    sdp_word_s   push_word;
    logic        drop;
    logic [11:0] code;
    logic [1:0]  pd_mode;
    logic        loaded;
    logic        update;
  } sdp_ctl_s;

endpackage

// ==== sdp_fifo.sv ====
// Word FIFO between the serial front end and the converter update logic
`timescale 1ns/1ps
module sdp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  // Depth must be a power of two; the extra pointer bit tells full from empty
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             full;
  logic             empty;
  logic             wr_en;
  logic             rd_en;

  assign empty         = (wr_ptr_reg == rd_ptr_reg);
  assign full          = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                         (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign wr_en         = in_valid_in && !full;
  assign rd_en         = out_ready_in && !empty;
  assign out_data_out  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (wr_en) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (rd_en) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr_en) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end

endmodule

// ==== sdp_port.sv ====
// Serial input port: pin sampling, frame decode and converter code update
`timescale 1ns/1ps
module sdp_port #(
  parameter int FIFO_DEPTH = sdp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // Serial pins from the host
  input  wire logic        sync_n_in,
  input  wire logic        sclk_in,
  input  wire logic        din_in,
  // Converter core
  input  wire logic        convert_ready_in,
  output logic [11:0]      analog_output_code_out,
  output logic [1:0]       power_down_out,
  output logic             code_valid_out,
  output logic             update_out,
  // Status
  output logic             frame_active_out,
  output logic             drop_out
);

  // ****************************************
  // State
  // ****************************************
  sdp_pkg::sdp_ctl_s  s_reg;
  sdp_pkg::sdp_ctl_s  s_next;
  sdp_pkg::sdp_word_s fifo_word;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               pop;
  logic               sclk_fall;
  logic               sync_rise;

  assign pop = fifo_out_valid && convert_ready_in;

  always_comb begin
    s_next        = s_reg;
    s_next.push   = 1'b0;
    s_next.drop   = 1'b0;
    s_next.update = 1'b0;

    // Three-stage sampling; a level is accepted once stages two and three agree
    // A pin level needs about three clk cycles to count, so each shift-clock phase
    // must last at least that long; host rates near 30 MHz are out of reach here
    s_next.sync_ff = {s_reg.sync_ff[1:0], sync_n_in};
    s_next.sclk_ff = {s_reg.sclk_ff[1:0], sclk_in};
    s_next.din_ff  = {s_reg.din_ff[1:0], din_in};
    if (s_reg.sync_ff[1] == s_reg.sync_ff[2]) begin
      s_next.sync_n_f = s_reg.sync_ff[2];
    end
    if (s_reg.sclk_ff[1] == s_reg.sclk_ff[2]) begin
      s_next.sclk_f = s_reg.sclk_ff[2];
    end
    if (s_reg.din_ff[1] == s_reg.din_ff[2]) begin
      s_next.din_f = s_reg.din_ff[2];
    end
    sclk_fall = s_reg.sclk_f && !s_next.sclk_f;
    sync_rise = !s_reg.sync_n_f && s_next.sync_n_f;

    case (s_reg.st)
      sdp_pkg::ST_IDLE: begin
        if (!s_next.sync_n_f) begin
          s_next.st  = sdp_pkg::ST_SHIFT;
          s_next.cnt = sdp_pkg::CNT_ZERO;
        end
      end
      sdp_pkg::ST_SHIFT: begin
        if (s_next.sync_n_f) begin
          // Early release: partial word is thrown away, code untouched
          s_next.st  = sdp_pkg::ST_IDLE;
          s_next.cnt = sdp_pkg::CNT_ZERO;
        end else if (sclk_fall) begin
          s_next.shreg = {s_reg.shreg[14:0], s_next.din_f};
          s_next.cnt   = s_reg.cnt + sdp_pkg::CNT_ONE;
          if (s_reg.cnt == sdp_pkg::LAST_BIT) begin
            s_next.st        = sdp_pkg::ST_HOLD;
            s_next.push      = 1'b1;
            s_next.push_word = {s_reg.shreg[14:0], s_next.din_f};
          end
        end
      end
      sdp_pkg::ST_HOLD: begin
        // Extra edges after the sixteenth are ignored until frame-sync rises
        if (s_next.sync_n_f) begin
          s_next.st  = sdp_pkg::ST_IDLE;
          s_next.cnt = sdp_pkg::CNT_ZERO;
        end
      end
      default: begin
        s_next.st = sdp_pkg::ST_IDLE;
      end
    endcase

    // The host cannot be stalled, so a word meeting a full FIFO is lost and flagged
    // Only the converter side can wait; the link side never sees back-pressure
    if (s_reg.push && !fifo_in_ready) begin
      s_next.drop = 1'b1;
    end

    if (pop) begin
      s_next.code    = fifo_word.code;
      s_next.pd_mode = fifo_word.pd_mode;
      s_next.loaded  = 1'b1;
      s_next.update  = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_reg.sync_ff   <= 3'h7;
      s_reg.sclk_ff   <= 3'h0;
      s_reg.din_ff    <= 3'h0;
      s_reg.sync_n_f  <= 1'b1;
      s_reg.sclk_f    <= 1'b0;
      s_reg.din_f     <= 1'b0;
      s_reg.st        <= sdp_pkg::ST_IDLE;
      s_reg.shreg     <= sdp_pkg::WORD_RESET;
      s_reg.cnt       <= sdp_pkg::CNT_ZERO;
      s_reg.push      <= 1'b0;
      s_reg.push_word <= sdp_pkg::WORD_RESET;
      s_reg.drop      <= 1'b0;
      s_reg.code      <= sdp_pkg::CODE_RESET;
      s_reg.pd_mode   <= sdp_pkg::PD_NORMAL;
      s_reg.loaded    <= 1'b0;
      s_reg.update    <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Word buffer
  // ****************************************
  sdp_fifo #(
    .WIDTH (sdp_pkg::WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (s_reg.push),
    .in_data_in    (s_reg.push_word),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_word),
    .out_ready_in  (convert_ready_in)
  );

  assign analog_output_code_out = s_reg.code;
  assign power_down_out         = s_reg.pd_mode;
  assign code_valid_out         = s_reg.loaded;
  assign update_out             = s_reg.update;
  assign frame_active_out       = (s_reg.st != sdp_pkg::ST_IDLE);
  assign drop_out               = s_reg.drop;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_idle_no_shift: assert property (
    (s_reg.st == sdp_pkg::ST_IDLE) |=> $stable(s_reg.shreg))
    else $error("shift register moved while frame-sync high");

  a_shift_on_fall: assert property (
    (s_reg.st == sdp_pkg::ST_SHIFT && sclk_fall && !s_next.sync_n_f)
      |=> (s_reg.shreg[0] == $past(s_next.din_f)) &&
          (s_reg.shreg[15:1] == $past(s_reg.shreg[14:0])))
    else $error("bit not shifted on falling clock edge");

  a_push_after_16: assert property (
    s_reg.push |-> (s_reg.cnt == sdp_pkg::BITS_PER_FRAME) &&
                   (s_reg.st == sdp_pkg::ST_HOLD))
    else $error("word pushed before sixteen edges");

  a_abort_drops: assert property (
    (s_reg.st == sdp_pkg::ST_SHIFT && sync_rise)
      |=> !s_reg.push && (s_reg.st == sdp_pkg::ST_IDLE) ##1 !s_reg.push)
    else $error("aborted frame produced a word");

  a_zero_until_load: assert property (
    !s_reg.loaded |-> (s_reg.code == sdp_pkg::CODE_RESET) && !s_reg.update)
    else $error("code nonzero before first write");

  a_pd_from_word: assert property (
    pop |=> (s_reg.pd_mode == $past(fifo_word.pd_mode)) && s_reg.update)
    else $error("power-down mode not taken from word");

  a_code_update: assert property (
    pop |=> (s_reg.code == $past(fifo_word.code)) ##1 $stable(s_reg.code) || s_reg.update)
    else $error("converter code not loaded from word");

  a_update_pairs: assert property (
    s_reg.update |-> $past(pop) && s_reg.loaded)
    else $error("update without a popped word");

  a_sync_gates_shift: assert property (
    (s_reg.st == sdp_pkg::ST_IDLE && s_next.sync_n_f) |=> (s_reg.st == sdp_pkg::ST_IDLE))
    else $error("frame started while frame-sync high");

  a_hold_ignores: assert property (
    (s_reg.st == sdp_pkg::ST_HOLD) |=> !s_reg.push && $stable(s_reg.shreg))
    else $error("edge after the sixteenth changed the word");

  a_sclk_filter: assert property (
    (s_reg.sclk_ff[1] != s_reg.sclk_ff[2]) |=> $stable(s_reg.sclk_f))
    else $error("shift clock level taken before two samples agree");

  a_full_drops: assert property (
    (s_reg.push && !fifo_in_ready) |=> s_reg.drop)
    else $error("word lost at full buffer without a drop pulse");

  a_drop_pairs: assert property (
    s_reg.drop |-> $past(s_reg.push) && $past(!fifo_in_ready))
    else $error("drop pulse without a word meeting a full buffer");

  c_full_frame: cover property (s_reg.push ##[1:40] s_reg.update);
  c_abort:      cover property (s_reg.st == sdp_pkg::ST_SHIFT && sync_rise);
  c_drop:       cover property (s_reg.drop);
  c_power_down: cover property (s_reg.update && s_reg.pd_mode != sdp_pkg::PD_NORMAL);
  c_extra_edge: cover property (s_reg.st == sdp_pkg::ST_HOLD && sclk_fall);

endmodule

// ==== sdp_host.sv ====
// Host-side model of the serial link: frame-sync, shift clock and data
`timescale 1ns/1ps
module sdp_host (
  // Serial pins to the port
  output logic sync_n_out,
  output logic sclk_out,
  output logic din_out
);
  // 400 ns shift-clock period (200 ns high, 200 ns low), far below the 30 MHz ceiling
  localparam time HALF = 200;

  initial begin
    sync_n_out = 1'b1;
    sclk_out   = 1'b1;
    din_out    = 1'b0;
  end

  // ****************************************
  // Frame driver
  // ****************************************
  // Fewer than 16 bits makes an early frame-sync rise, i.e. an abort;
  // more than 16 adds trailing edges that carry zeros
  task automatic send(input logic [15:0] word, input int nbits);
    sync_n_out = 1'b0;
    #(HALF);
    for (int i = 15; i > 15 - nbits; i--) begin
      din_out = (i >= 0) ? word[i] : 1'b0;
      #(HALF);
      sclk_out = 1'b0;
      #(HALF);
      sclk_out = 1'b1;
    end
    #(HALF);
    sync_n_out = 1'b1;
    // Released data line must not keep showing the last bit
    din_out = ~din_out;
    #(2 * HALF);
  endtask
endmodule

// ==== tb.sv ====
// Self-checking testbench for the serial converter input port
`timescale 1ns/1ps
module tb;
  logic        clk_in;
  logic        reset_in;
  logic        convert_ready_in;
  logic        sync_n;
  logic        sclk;
  logic        din;
  logic [11:0] code;
  logic [1:0]  pd;
  logic        code_valid;
  logic        update;
  logic        frame_active;
  logic        drop;
  int          err_count;
  int          samples_checked;
  int          upd_count;
  int          drop_count;

  sdp_host host (.sync_n_out(sync_n), .sclk_out(sclk), .din_out(din));

  sdp_port #(.FIFO_DEPTH(16)) uut (
    .clk_in                 (clk_in),
    .reset_in               (reset_in),
    .sync_n_in              (sync_n),
    .sclk_in                (sclk),
    .din_in                 (din),
    .convert_ready_in       (convert_ready_in),
    .analog_output_code_out (code),
    .power_down_out         (pd),
    .code_valid_out         (code_valid),
    .update_out             (update),
    .frame_active_out       (frame_active),
    .drop_out               (drop)
  );

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // One-cycle pulses are counted in the cycle they stand
  always @(posedge clk_in) begin
    if (update === 1'b1) upd_count++;
    if (drop === 1'b1) drop_count++;
  end

  // ****************************************
  // Shared checks
  // ****************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_updates(input int n);
    for (int i = 0; i < 800 && upd_count < n; i++) @(posedge clk_in);
    if (upd_count < n) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, upd_count, n);
    end
  endtask

  // Link pins change just after a rising edge; host delays are whole clk periods
  task automatic send_frame(input logic [15:0] word, input int nbits);
    @(posedge clk_in);
    #1;
    host.send(word, nbits);
  endtask

  task automatic close_out();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    @(negedge clk_in);
    check(16'(code), 16'h0000);
    check(16'(pd), 16'h0000);
    check(16'({code_valid, frame_active}), 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_abort();
    send_frame(16'h3FFF, 10);
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    check(16'(upd_count), 16'h0000);
    check(16'({code_valid, code}), 16'h0000);
    check(16'(frame_active), 16'h0000);
    $display("test abort done");
  endtask

  task automatic t_frames();
    logic [11:0] codes [4];
    codes = '{12'hFFF, 12'h001, 12'h800, 12'h000};
    for (int m = 0; m < 4; m++) begin
      // Spare bits set to show they are ignored
      send_frame({2'h3, 2'(m), codes[m]}, 16);
      wait_updates(m + 1);
      @(negedge clk_in);
      check(16'(code), 16'(codes[m]));
      check(16'(pd), 16'(m));
      check(16'(code_valid), 16'h0001);
    end
    $display("test frames done");
  endtask

  task automatic t_fill();
    int base;
    base = upd_count;
    @(posedge clk_in);
    #1 convert_ready_in = 1'b0;
    for (int i = 0; i < 17; i++) send_frame(16'h0100 + 16'(i), 16);
    repeat (10) @(posedge clk_in);
    @(negedge clk_in);
    check(16'(drop_count), 16'h0001);
    check(16'(upd_count - base), 16'h0000);
    check(16'({pd, code}), 16'h3000);
    @(posedge clk_in);
    #1 convert_ready_in = 1'b1;
    wait_updates(base + 16);
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    check(16'(upd_count - base), 16'h0010);
    check(16'({pd, code}), 16'h010F);
    $display("test fill done");
  endtask

  task automatic t_rerun();
    @(posedge clk_in);
    #1 reset_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 reset_in = 1'b0;
    @(negedge clk_in);
    check(16'({code_valid, pd, code}), 16'h0000);
    check(16'({update, drop, frame_active}), 16'h0000);
    $display("test rerun done");
  endtask

  task automatic t_extra();
    int base;
    base = upd_count;
    send_frame(16'h1ABC, 18);
    wait_updates(base + 1);
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    check(16'(upd_count - base), 16'h0001);
    check(16'({pd, code}), 16'h1ABC);
    check(16'(code_valid), 16'h0001);
    $display("test extra done");
  endtask

  initial begin
    #(1_000_000);
    err_count++;
    close_out();
  end

  initial begin
    err_count        = 0;
    samples_checked  = 0;
    upd_count        = 0;
    drop_count       = 0;
    reset_in         = 1'b1;
    convert_ready_in = 1'b1;
    repeat (16) @(posedge clk_in);
    #1 reset_in = 1'b0;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_abort();
    t_frames();
    t_fill();
    t_rerun();
    t_extra();
    close_out();
  end
endmodule
